// *** logic/indicator_blink_and_pin_routing.sv ***
// Purpose: Two-indicator blink timing and digital pin routing
// Assumes: Management port is synchronous to core_clk; pins_in is asynchronous
// Notes: Every output is registered, so pins lag their cause by at least one cycle
//
// Summary of operation
// - Indicator 0 lit count, bits 15:8
// - Indicator 0 dark count, bits 7:0
// - Indicator 1 lit count, bits 15:8
// - Indicator 1 dark count, reset 0x36
// - Mode 0 blinks dark first, then lit
// - Mode 1 blinks lit first, then dark
// - Both counts zero shows source live
// - Link source: lit on idle link, blinks on activity, dark without link
// - Activity source: dark idle, blinks on activity
// - Indicator 1 pin routing, 111 disables
// - Timestamp timer output pin routing
// - Timestamp capture input pin routing
// - Mode bit selects blink ordering style
// - Disabled indicator stays off
`timescale 1ns/100ps
module indicator_blink_and_pin_routing #(
  parameter int unsigned TICK_CYCLES = ind_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic link_up,
  input wire logic [1:0] activity,
  input wire logic [1:0] ind_enable,
  input wire logic [1:0] ind_blink_mode,
  input wire ind_pkg::ind_source_t ind0_source_select,
  input wire ind_pkg::ind_source_t ind1_source_select,
  input wire logic irq_in_n,
  input wire logic timestamp_timer_out,
  input wire ind_pkg::pin_in_t pins_in,
  output logic indicator0_pin,
  output logic indicator1_pin_out,
  output logic indicator1_pin_oe,
  output logic rxd1_ts_out,
  output logic rxd1_ts_oe,
  output logic irq_pin_n,
  output logic link_state_out,
  output logic timestamp_capture_in,
  output logic ts_capture_valid
);
  localparam int TW = $clog2(TICK_CYCLES);

  ind_pkg::blink_time_t time_reg [2];
  ind_pkg::pin_route_t route_reg;
  ind_pkg::pin_in_t pin_s1_reg;
  ind_pkg::pin_in_t pin_s2_reg;
  ind_pkg::phase_t phase_reg [2];
  ind_pkg::ind_source_t src [2];
  logic [7:0] cnt_reg [2];
  logic [TW-1:0] tick_cnt_reg;
  logic tick_reg;
  logic [1:0] run;
  logic [1:0] live;
  logic [1:0] ind_on_reg;
  logic ind1_pin_next;
  logic capt_next;

  // Start phase follows the mode bit
  function automatic ind_pkg::phase_t start_phase(input logic mode);
    start_phase = mode ? ind_pkg::PH_LIT : ind_pkg::PH_DARK;
  endfunction : start_phase

  function automatic logic ind_level(input ind_pkg::ind_source_t s, input logic lnk,
                                     input logic act, input logic lv, input logic lit);
    case (s)
      ind_pkg::SRC_LINK_ACT: ind_level = lnk && (!act || (!lv && lit));
      ind_pkg::SRC_ACT_ONLY: ind_level = act && (lv || lit);
      ind_pkg::SRC_ON: ind_level = 1'b1;
      default: ind_level = 1'b0;
    endcase
  endfunction : ind_level

  assign src[0] = ind0_source_select;
  assign src[1] = ind1_source_select;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      live[i] = (time_reg[i] == '0);
      run[i] = activity[i] && !live[i] &&
               ((src[i] == ind_pkg::SRC_ACT_ONLY) ||
                (src[i] == ind_pkg::SRC_LINK_ACT && link_up));
    end
  end

  // ==========================================================
  // Input pin synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= pins_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ==========================================================
  // Management registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      time_reg[0] <= ind_pkg::BLINK_TIME_RESET;
      time_reg[1] <= ind_pkg::BLINK_TIME_RESET;
      route_reg <= ind_pkg::PIN_ROUTE_RESET;
    end else if (mgmt_wr) begin
      if (mgmt_addr == ind_pkg::IND0_TIME_ADDR) begin
        time_reg[0] <= mgmt_wdata;
      end else if (mgmt_addr == ind_pkg::IND1_TIME_ADDR) begin
        time_reg[1] <= mgmt_wdata;
      end else if (mgmt_addr == ind_pkg::PIN_ROUTE_ADDR) begin
        route_reg <= mgmt_wdata & ind_pkg::PIN_ROUTE_WMASK;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mgmt_rdata <= ind_pkg::RDATA_NONE;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (!mgmt_rd) begin
        mgmt_rdata <= ind_pkg::RDATA_NONE;
      end else if (mgmt_addr == ind_pkg::IND0_TIME_ADDR) begin
        mgmt_rdata <= time_reg[0];
      end else if (mgmt_addr == ind_pkg::IND1_TIME_ADDR) begin
        mgmt_rdata <= time_reg[1];
      end else if (mgmt_addr == ind_pkg::PIN_ROUTE_ADDR) begin
        mgmt_rdata <= route_reg;
      end else begin
        mgmt_rdata <= ind_pkg::RDATA_NONE;
      end
    end
  end

  // ==========================================================
  // 4 ms tick prescaler
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Blink phase engines
  // Idle engines sit armed at their start phase, so a burst always
  // opens with its start phase rather than mid-cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        phase_reg[i] <= ind_pkg::PH_DARK;
        cnt_reg[i] <= ind_pkg::NO_TICKS;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!run[i]) begin
          phase_reg[i] <= start_phase(ind_blink_mode[i]);
          cnt_reg[i] <= ind_blink_mode[i] ? time_reg[i].lit_ticks
                                           : time_reg[i].dark_ticks;
        end else if (tick_reg) begin
          if (cnt_reg[i] <= ind_pkg::LAST_TICK) begin
            phase_reg[i] <= (phase_reg[i] == ind_pkg::PH_LIT) ? ind_pkg::PH_DARK
                                                               : ind_pkg::PH_LIT;
            cnt_reg[i] <= (phase_reg[i] == ind_pkg::PH_LIT) ? time_reg[i].dark_ticks
                                                             : time_reg[i].lit_ticks;
          end else begin
            cnt_reg[i] <= cnt_reg[i] - 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ind_on_reg <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        ind_on_reg[i] <= ind_enable[i] &&
                         ind_level(src[i], link_up, activity[i], live[i],
                                   phase_reg[i] == ind_pkg::PH_LIT);
      end
    end
  end

  // ==========================================================
  // Pin routing
  always_comb begin
    case (route_reg.ind1_pin_route)
      ind_pkg::IND1_ROUTE_IND: ind1_pin_next = ind_on_reg[1];
      ind_pkg::IND1_ROUTE_TX_ER: ind1_pin_next = pin_s2_reg.tx_er;
      ind_pkg::IND1_ROUTE_TX_EN: ind1_pin_next = pin_s2_reg.tx_en;
      ind_pkg::IND1_ROUTE_TX_CLK: ind1_pin_next = pin_s2_reg.tx_clk;
      ind_pkg::IND1_ROUTE_TXD0: ind1_pin_next = pin_s2_reg.txd0;
      ind_pkg::IND1_ROUTE_TXD2: ind1_pin_next = pin_s2_reg.txd2;
      ind_pkg::IND1_ROUTE_LINK: ind1_pin_next = link_up ^ route_reg.link_out_polarity;
      default: ind1_pin_next = 1'b0;
    endcase
    case (route_reg.ts_capture_route)
      ind_pkg::CAPT_ROUTE_TXD1: capt_next = pin_s2_reg.txd1;
      ind_pkg::CAPT_ROUTE_IND1: capt_next = pin_s2_reg.ind1_in;
      ind_pkg::CAPT_ROUTE_MDIO: capt_next = pin_s2_reg.mdio_in;
      default: capt_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      indicator0_pin <= 1'b0;
      indicator1_pin_out <= 1'b0;
      indicator1_pin_oe <= 1'b0;
      rxd1_ts_out <= 1'b0;
      rxd1_ts_oe <= 1'b0;
      irq_pin_n <= 1'b1;
      link_state_out <= 1'b0;
      timestamp_capture_in <= 1'b0;
      ts_capture_valid <= 1'b0;
    end else begin
      indicator0_pin <= (route_reg.timestamp_timer_out_route == ind_pkg::TMR_ROUTE_IND0) ?
                        timestamp_timer_out : ind_on_reg[0];
      indicator1_pin_out <= ind1_pin_next;
      // Pin turns input when it carries the capture signal
      indicator1_pin_oe <= (route_reg.ind1_pin_route != ind_pkg::IND1_ROUTE_OFF) &&
                           (route_reg.ts_capture_route != ind_pkg::CAPT_ROUTE_IND1);
      rxd1_ts_out <= timestamp_timer_out;
      rxd1_ts_oe <= (route_reg.timestamp_timer_out_route == ind_pkg::TMR_ROUTE_RXD1);
      irq_pin_n <= (route_reg.timestamp_timer_out_route == ind_pkg::TMR_ROUTE_IRQ) ?
                   timestamp_timer_out : irq_in_n;
      link_state_out <= link_up ^ route_reg.link_out_polarity;
      timestamp_capture_in <= capt_next;
      ts_capture_valid <= !route_reg.ts_capture_route[1] ||
                          !route_reg.ts_capture_route[0];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_reset_time;
    $fell(rst) |-> time_reg[0] == ind_pkg::BLINK_TIME_RESET &&
                   time_reg[1].dark_ticks == ind_pkg::BLINK_TIME_RESET[7:0];
  endproperty
  a_reset_time: assert property (p_reset_time) else $error("blink reset value wrong");

  property p_write0;
    mgmt_wr && mgmt_addr == ind_pkg::IND0_TIME_ADDR |=>
      time_reg[0].dark_ticks == $past(mgmt_wdata[7:0]);
  endproperty
  a_write0: assert property (p_write0) else $error("ind0 dark not written");

  property p_write1;
    mgmt_wr && mgmt_addr == ind_pkg::IND1_TIME_ADDR |=>
      time_reg[1].lit_ticks == $past(mgmt_wdata[15:8]);
  endproperty
  a_write1: assert property (p_write1) else $error("ind1 lit not written");

  property p_start_dark;
    !run[0] && !ind_blink_mode[0] |=> phase_reg[0] == ind_pkg::PH_DARK;
  endproperty
  a_start_dark: assert property (p_start_dark) else $error("mode 0 not dark first");

  property p_start_lit;
    !run[1] && ind_blink_mode[1] |=> phase_reg[1] == ind_pkg::PH_LIT;
  endproperty
  a_start_lit: assert property (p_start_lit) else $error("mode 1 not lit first");

  property p_live;
    ind_enable[0] && src[0] == ind_pkg::SRC_ACT_ONLY && live[0] |=>
      ind_on_reg[0] == $past(activity[0]);
  endproperty
  a_live: assert property (p_live) else $error("live view mismatch");

  property p_link_lost;
    src[1] == ind_pkg::SRC_LINK_ACT && !link_up |=> !ind_on_reg[1];
  endproperty
  a_link_lost: assert property (p_link_lost) else $error("lit without link");

  property p_act_idle;
    src[0] == ind_pkg::SRC_ACT_ONLY && !activity[0] |=> !ind_on_reg[0];
  endproperty
  a_act_idle: assert property (p_act_idle) else $error("lit without activity");

  property p_ind1_off;
    route_reg.ind1_pin_route == ind_pkg::IND1_ROUTE_OFF |=> !indicator1_pin_oe;
  endproperty
  a_ind1_off: assert property (p_ind1_off) else $error("disabled pin driven");

  property p_disabled;
    !ind_enable[1] |=> !ind_on_reg[1];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled indicator lit");

  property p_tick;
    tick_reg |=> !tick_reg;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too long");

  property p_polarity;
    ##1 link_state_out == ($past(link_up) ^ $past(route_reg.link_out_polarity));
  endproperty
  a_polarity: assert property (p_polarity) else $error("link output polarity");

  c_blink_lit: cover property (run[0] ##1 phase_reg[0] == ind_pkg::PH_LIT);
  c_live: cover property (live[1] && activity[1] ##1 ind_on_reg[1]);
  c_route: cover property (route_reg.ind1_pin_route == ind_pkg::IND1_ROUTE_LINK);
endmodule : indicator_blink_and_pin_routing

// *** shared/ind_pkg.sv ***
// Purpose: Shared constants and types for indicator blink and pin routing
// Assumes: 40 MHz core clock, 16-bit management registers
// Notes: Field layouts are carried by the packed structs below
package ind_pkg;
  // ==========================================================
  // Register map
  localparam logic [15:0] PIN_ROUTE_ADDR = 16'h8c56;
  localparam logic [15:0] IND0_TIME_ADDR = 16'h8c80;
  localparam logic [15:0] IND1_TIME_ADDR = 16'h8c81;
  localparam logic [15:0] PIN_ROUTE_RESET = 16'h00fe;
  localparam logic [15:0] BLINK_TIME_RESET = 16'h3636;
  localparam logic [15:0] PIN_ROUTE_WMASK = 16'h00ff;
  localparam logic [15:0] RDATA_NONE = 16'h0000;

  typedef struct packed {
    logic [7:0] lit_ticks;
    logic [7:0] dark_ticks;
  } blink_time_t;

  typedef struct packed {
    logic [7:0] reserved;
    logic [1:0] timestamp_timer_out_route;
    logic [1:0] ts_capture_route;
    logic [2:0] ind1_pin_route;
    logic link_out_polarity;
  } pin_route_t;

  // ==========================================================
  // Route codes
  localparam logic [2:0] IND1_ROUTE_IND = 3'h0;
  localparam logic [2:0] IND1_ROUTE_TX_ER = 3'h1;
  localparam logic [2:0] IND1_ROUTE_TX_EN = 3'h2;
  localparam logic [2:0] IND1_ROUTE_TX_CLK = 3'h3;
  localparam logic [2:0] IND1_ROUTE_TXD0 = 3'h4;
  localparam logic [2:0] IND1_ROUTE_TXD2 = 3'h5;
  localparam logic [2:0] IND1_ROUTE_LINK = 3'h6;
  localparam logic [2:0] IND1_ROUTE_OFF = 3'h7;
  localparam logic [1:0] TMR_ROUTE_RXD1 = 2'h0;
  localparam logic [1:0] TMR_ROUTE_IND0 = 2'h1;
  localparam logic [1:0] TMR_ROUTE_IRQ = 2'h2;
  localparam logic [1:0] CAPT_ROUTE_TXD1 = 2'h0;
  localparam logic [1:0] CAPT_ROUTE_IND1 = 2'h1;
  localparam logic [1:0] CAPT_ROUTE_MDIO = 2'h2;

  // ==========================================================
  // Sources, phases, timing
  typedef enum logic [1:0] {SRC_LINK_ACT, SRC_ACT_ONLY, SRC_ON, SRC_OFF} ind_source_t;
  typedef enum logic {PH_DARK, PH_LIT} phase_t;

  localparam int unsigned TICK_MS = 4;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] LAST_TICK = 8'h01;
  localparam logic [7:0] NO_TICKS = 8'h00;

  typedef struct packed {
    logic tx_er;
    logic tx_en;
    logic tx_clk;
    logic txd0;
    logic txd1;
    logic txd2;
    logic ind1_in;
    logic mdio_in;
  } pin_in_t;
endpackage : ind_pkg

// *** test/pin_partner.sv ***
// Purpose: Board model of the pins around the indicator block
// Assumes: The lamp on the indicator 1 pin pulls the wire low when undriven
// Notes: The resolved wire is fed back as the indicator 1 pin input
`timescale 1ns/100ps
module pin_partner (
  input wire logic ind1_out,
  input wire logic ind1_oe,
  input wire logic ext_val,
  input wire logic ext_oe,
  input wire ind_pkg::pin_in_t drv,
  output ind_pkg::pin_in_t pins
);
  // ==========================================================
  // Wire resolution
  logic wire_lvl;
  // Pull-down level, not the last value, once both sides let go
  assign wire_lvl = ind1_oe ? ind1_out : (ext_oe ? ext_val : 1'b0);
  always_comb begin
    pins = drv;
    pins.ind1_in = wire_lvl;
  end
endmodule : pin_partner

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for indicator blink and pin routing
// Assumes: Prescaler shortened to 4 cycles per tick
// Notes: Blink counts kept above three; live view uses zero counts
`timescale 1ns/100ps
module tb_top;
  // ==========================================================
  // Signals and instances
  localparam int unsigned TK = 4;
  logic core_clk, rst, mgmt_wr, mgmt_rd, link_up, irq_in_n, ts_tmr, rvalid;
  logic [15:0] mgmt_addr, mgmt_wdata, mgmt_rdata;
  logic [1:0] activity, ind_enable, ind_blink_mode, ind_pins;
  ind_pkg::ind_source_t src0, src1;
  ind_pkg::pin_in_t pin_drv, pins_in;
  logic ext_val, ext_oe, ind0, ind1_out, ind1_oe, rxd_out, rxd_oe;
  logic irq_n, link_o, capt, capt_v;
  int err_total, checked, cycles;
  assign ind_pins = {ind1_out, ind0};

  indicator_blink_and_pin_routing #(.TICK_CYCLES(TK)) dut_u (
    .core_clk(core_clk), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(rvalid),
    .link_up(link_up), .activity(activity), .ind_enable(ind_enable),
    .ind_blink_mode(ind_blink_mode), .ind0_source_select(src0), .ind1_source_select(src1),
    .irq_in_n(irq_in_n), .timestamp_timer_out(ts_tmr), .pins_in(pins_in),
    .indicator0_pin(ind0), .indicator1_pin_out(ind1_out), .indicator1_pin_oe(ind1_oe),
    .rxd1_ts_out(rxd_out), .rxd1_ts_oe(rxd_oe), .irq_pin_n(irq_n),
    .link_state_out(link_o), .timestamp_capture_in(capt), .ts_capture_valid(capt_v));
  pin_partner partner_u (.ind1_out(ind1_out), .ind1_oe(ind1_oe), .ext_val(ext_val),
    .ext_oe(ext_oe), .drv(pin_drv), .pins(pins_in));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic stop_test();
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    mgmt_addr <= a;
    mgmt_wdata <= d;
    mgmt_wr <= 1'b1;
    @(posedge core_clk);
    mgmt_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string nm);
    @(posedge core_clk);
    mgmt_addr <= a;
    mgmt_rd <= 1'b1;
    @(posedge core_clk);
    mgmt_rd <= 1'b0;
    #1;
    chk("rvalid", 16'(rvalid), 16'h0001);
    chk(nm, mgmt_rdata, exp);
  endtask : rd
  function automatic logic [15:0] rt(input logic [1:0] t, input logic [1:0] c,
                                     input logic [2:0] i, input logic p);
    return {8'h00, t, c, i, p};
  endfunction : rt
  // Counts cycles the indicator holds one level; bounded so a stuck pin ends
  task automatic run(input int x, input logic lvl, output int n);
    n = 0;
    while (ind_pins[x] === lvl && n < 4000) begin
      n++;
      step(1);
    end
  endtask : run

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(ind_pkg::PIN_ROUTE_ADDR, 16'h00fe, "route_rst");
    rd(ind_pkg::IND0_TIME_ADDR, 16'h3636, "ind0_rst");
    rd(ind_pkg::IND1_TIME_ADDR, 16'h3636, "ind1_rst");
    wr(ind_pkg::PIN_ROUTE_ADDR, 16'hffff);
    rd(ind_pkg::PIN_ROUTE_ADDR, 16'h00ff, "route_ro");
    rd(16'h8c82, 16'h0000, "unmapped");
    wr(ind_pkg::IND0_TIME_ADDR, 16'ha55a);
    wr(ind_pkg::IND1_TIME_ADDR, 16'h5aa5);
    rd(ind_pkg::IND0_TIME_ADDR, 16'ha55a, "ind0_rw");
    rd(ind_pkg::IND1_TIME_ADDR, 16'h5aa5, "ind1_rw");
  endtask : t_reset
  task automatic t_live();
    logic [4:0] tbl[7] = '{5'b00101, 5'b00110, 5'b00000, 5'b01000, 5'b01011,
                           5'b10001, 5'b11110};
    wr(ind_pkg::IND0_TIME_ADDR, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      src0 <= ind_pkg::ind_source_t'(tbl[i][4:3]);
      src1 <= ind_pkg::ind_source_t'(tbl[i][4:3]);
      link_up <= tbl[i][2];
      activity <= {1'b0, tbl[i][1]};
      step(4);
      chk("live", 16'(ind0), 16'(tbl[i][0]));
    end
    @(posedge core_clk);
    src0 <= ind_pkg::SRC_ON;
    src1 <= ind_pkg::SRC_ON;
    ind_enable <= 2'b00;
    step(4);
    chk("disabled", 16'(ind0), 16'h0000);
    @(posedge core_clk);
    ind_enable <= 2'b11;
  endtask : t_live
  task automatic t_ind1_route();
    int sh[7] = '{0, 7, 6, 5, 4, 2, 0};
    wr(ind_pkg::IND1_TIME_ADDR, 16'h0000);
    for (int c = 0; c < 7; c++) begin
      wr(ind_pkg::PIN_ROUTE_ADDR, rt(2'h3, 2'h3, 3'(c), 1'b0));
      @(posedge core_clk);
      pin_drv <= '0;
      link_up <= 1'b0;
      src1 <= ind_pkg::SRC_OFF;
      step(5);
      chk("ind1_low", 16'(ind1_out), 16'h0000);
      @(posedge core_clk);
      if (c == 0) src1 <= ind_pkg::SRC_ON;
      else if (c == 6) link_up <= 1'b1;
      else pin_drv <= ind_pkg::pin_in_t'(8'h01 << sh[c]);
      step(5);
      chk("ind1_high", 16'(ind1_out), 16'h0001);
      chk("ind1_oe", 16'(ind1_oe), 16'h0001);
    end
    wr(ind_pkg::PIN_ROUTE_ADDR, rt(2'h3, 2'h3, 3'h7, 1'b0));
    step(3);
    chk("ind1_off", 16'(ind1_oe), 16'h0000);
  endtask : t_ind1_route
  task automatic t_timer();
    @(posedge core_clk);
    src0 <= ind_pkg::SRC_OFF;
    ts_tmr <= 1'b1;
    irq_in_n <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(ind_pkg::PIN_ROUTE_ADDR, rt(2'(c), 2'h3, 3'h7, 1'b0));
      step(3);
      chk("rxd_oe", 16'(rxd_oe), 16'(c == 0));
      if (c == 0) chk("rxd_out", 16'(rxd_out), 16'h0001);
      chk("ind0_tmr", 16'(ind0), 16'(c == 1));
      chk("irq_tmr", 16'(irq_n), 16'(c == 2));
    end
    @(posedge core_clk);
    ts_tmr <= 1'b0;
    irq_in_n <= 1'b1;
    step(3);
    chk("rxd_low", 16'(rxd_out), 16'h0000);
    chk("irq_pass", 16'(irq_n), 16'h0001);
  endtask : t_timer
  task automatic t_capture();
    int sh[4] = '{3, 1, 0, 0};
    for (int c = 0; c < 4; c++) begin
      wr(ind_pkg::PIN_ROUTE_ADDR, rt(2'h3, 2'(c), 3'h0, 1'b0));
      @(posedge core_clk);
      pin_drv <= '0;
      ext_val <= 1'b0;
      ext_oe <= (c == 1);
      src1 <= ind_pkg::SRC_OFF;
      step(5);
      chk("capt_low", 16'(capt), 16'h0000);
      @(posedge core_clk);
      pin_drv <= ind_pkg::pin_in_t'(8'h01 << sh[c]);
      ext_val <= 1'b1;
      step(5);
      chk("capt_high", 16'(capt), 16'(c != 3));
      chk("capt_v", 16'(capt_v), 16'(c != 3));
      chk("ind1_oe_c", 16'(ind1_oe), 16'(c != 1));
    end
    @(posedge core_clk);
    ext_oe <= 1'b0;
  endtask : t_capture
  task automatic t_polarity();
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      link_up <= k[1];
      wr(ind_pkg::PIN_ROUTE_ADDR, rt(2'h3, 2'h3, 3'h7, k[0]));
      step(3);
      chk("link_pol", 16'(link_o), 16'(k[1] ^ k[0]));
    end
  endtask : t_polarity
  task automatic t_blink(input int x, input logic m, input logic [7:0] lit,
                         input logic [7:0] dark);
    int n;
    wr(x ? ind_pkg::IND1_TIME_ADDR : ind_pkg::IND0_TIME_ADDR, {lit, dark});
    wr(ind_pkg::PIN_ROUTE_ADDR, rt(2'h3, 2'h3, 3'h0, 1'b0));
    @(posedge core_clk);
    src0 <= ind_pkg::SRC_ACT_ONLY;
    src1 <= ind_pkg::SRC_ACT_ONLY;
    activity <= 2'b00;
    ind_blink_mode <= {m, m};
    step(8);
    chk("blink_idle", 16'(ind_pins[x]), 16'h0000);
    @(posedge core_clk);
    activity[x] <= 1'b1;
    step(3);
    chk("blink_first", 16'(ind_pins[x]), 16'(m));
    // First phase may be cut short by the free-running prescaler
    run(x, m, n);
    chk("phase1", 16'(n != 0), 16'h0001);
    run(x, !m, n);
    chk("phase2", 16'(n), 16'(TK * (m ? dark : lit)));
    run(x, m, n);
    chk("phase3", 16'(n), 16'(TK * (m ? lit : dark)));
    @(posedge core_clk);
    activity <= 2'b00;
  endtask : t_blink

  // ==========================================================
  // Main sequence and watchdog
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    mgmt_addr = 16'h0000;
    mgmt_wdata = 16'h0000;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    link_up = 1'b0;
    activity = 2'b00;
    ind_enable = 2'b11;
    ind_blink_mode = 2'b00;
    src0 = ind_pkg::SRC_OFF;
    src1 = ind_pkg::SRC_OFF;
    irq_in_n = 1'b1;
    ts_tmr = 1'b0;
    pin_drv = '0;
    ext_val = 1'b0;
    ext_oe = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_live();
    t_ind1_route();
    t_timer();
    t_capture();
    t_polarity();
    t_blink(0, 1'b0, 8'h05, 8'h04);
    t_blink(1, 1'b1, 8'h04, 8'h06);
    stop_test();
  end
endmodule : tb_top
